// ### core/fpsl_pkg.sv
// constants and types for the flash protection and security host controller
// Summary of operation
// - high-id-voltage on reset pin unprotects temporarily
// - id pin high voltage reads maker/device code
// - id pin high voltage, A1 high reads protect
// - enter sequence maps boot addresses onto security
// - lock: enter sequence then protect algorithm
// - host exits security region before main array
// - write only with ce, we low, oe high
package fpsl_pkg;
	// software register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_WDATA = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_RDATA = 4'h4;
	// ctrl register bit positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_RD = 1;
	localparam int CTRL_WP_LOW = 2;
	localparam int CTRL_RST_ID = 3;
	localparam int CTRL_A9_ID = 4;
	localparam int CTRL_CMD_LO = 8;
	// command codes written to ctrl bits 10:8
	localparam logic [2:0] CMD_RAW = 3'h0;
	localparam logic [2:0] CMD_ENTER_SEC = 3'h1;
	localparam logic [2:0] CMD_EXIT_SEC = 3'h2;
	localparam logic [2:0] CMD_RESET = 3'h3;
	localparam logic [2:0] CMD_ID_READ = 3'h4;
	// unlock sequence words (word mode)
	localparam logic [21:0] UNLOCK_A1 = 22'h000555;
	localparam logic [21:0] UNLOCK_A2 = 22'h0002AA;
	localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
	localparam logic [15:0] UNLOCK_D2 = 16'h0055;
	localparam logic [15:0] DATA_ENTER = 16'h0088;
	localparam logic [15:0] DATA_IDSEL = 16'h0090;
	localparam logic [15:0] DATA_EXIT = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h00F0;
	// status bit for security indicator readout
	localparam int SEC_IND_BIT = 7;
	// timing: strobe low pulse, comfortably above the glitch filter
	localparam int STROBE_NS = 100;
	localparam int CLK_NS = 50;
	localparam logic [3:0] STROBE_CYC =
		4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	// host sequencer states
	typedef enum logic [2:0] {
		FPSL_IDLE = 3'b000,
		FPSL_SETUP = 3'b001,
		FPSL_LOW = 3'b010,
		FPSL_HOLD = 3'b011,
		FPSL_NEXT = 3'b100
	} fpsl_state_t;
endpackage

// ### core/fpsl_host.sv
// host controller driving the flash strobes, address, data and id voltages
`timescale 1ns/10ps
module fpsl_host (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output logic [21:0] fl_addr,
	output logic [15:0] fl_dq_out,
	output logic fl_dq_oe_n,
	input wire logic [15:0] fl_dq_in,
	output logic fl_ce_n,
	output logic fl_oe_n,
	output logic fl_we_n,
	output logic fl_reset_n,
	output logic fl_reset_id,
	output logic fl_a9_id,
	output logic write_protect_accel_pin
);
	// software-visible control and pending transfer
	logic [10:0] ctrl_q, ctrl_d;
	logic [21:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d;
	logic [15:0] rdata_q, rdata_d;
	logic [31:0] rd_q, rd_d;
	logic in_sec_q, in_sec_d; // host belief of security mode
	logic sec_locked_q, sec_locked_d; // indicator bit seen as one
	// sequencer
	fpsl_pkg::fpsl_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [2:0] step_q, step_d; // index in the command sequence
	logic [2:0] nsteps_q, nsteps_d;
	logic is_read_q, is_read_d;
	logic busy;
	logic [21:0] seq_addr;
	logic [15:0] seq_data;
	logic seq_read;

	assign busy = (st_q != fpsl_pkg::FPSL_IDLE);

	// pick address and data of the current step of the command
	always_comb begin
		seq_addr = addr_q;
		seq_data = wdata_q;
		seq_read = 1'b0;
		case (step_q)
			3'd0: begin
				// raw commands use the software word directly; reset writes F0 to the software address
				if (ctrl_q[10:8] != fpsl_pkg::CMD_RAW &&
					ctrl_q[10:8] != fpsl_pkg::CMD_RESET) begin
					seq_addr = fpsl_pkg::UNLOCK_A1;
					seq_data = fpsl_pkg::UNLOCK_D1;
				end else if (ctrl_q[10:8] == fpsl_pkg::CMD_RESET) begin
					seq_data = fpsl_pkg::DATA_RESET;
				end else begin
					seq_read = is_read_q;
				end
			end
			3'd1: begin
				seq_addr = fpsl_pkg::UNLOCK_A2;
				seq_data = fpsl_pkg::UNLOCK_D2;
			end
			3'd2: begin
				seq_addr = fpsl_pkg::UNLOCK_A1;
				seq_data = (ctrl_q[10:8] == fpsl_pkg::CMD_ENTER_SEC) ?
					fpsl_pkg::DATA_ENTER : fpsl_pkg::DATA_IDSEL;
			end
			3'd3: begin
				// exit writes 00, id read reads the given address
				if (ctrl_q[10:8] == fpsl_pkg::CMD_EXIT_SEC) begin
					seq_data = fpsl_pkg::DATA_EXIT;
				end else begin
					seq_read = 1'b1;
				end
			end
			default: begin
				seq_read = 1'b0;
			end
		endcase
	end

	// register file writes and sequencer next state
	always_comb begin
		ctrl_d = ctrl_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		in_sec_d = in_sec_q;
		sec_locked_d = sec_locked_q;
		st_d = st_q;
		cnt_d = cnt_q;
		step_d = step_q;
		nsteps_d = nsteps_q;
		is_read_d = is_read_q;
		// go bit self-clears; writes during a transfer are dropped
		ctrl_d[fpsl_pkg::CTRL_GO] = 1'b0;
		if (sw_wr && !busy) begin
			case (sw_addr)
				fpsl_pkg::REG_CTRL: ctrl_d = sw_wdata[10:0];
				fpsl_pkg::REG_ADDR: addr_d = sw_wdata[21:0];
				fpsl_pkg::REG_WDATA: wdata_d = sw_wdata[15:0];
				default: ;
			endcase
		end
		case (st_q)
			fpsl_pkg::FPSL_IDLE: begin
				if (ctrl_q[fpsl_pkg::CTRL_GO]) begin
					st_d = fpsl_pkg::FPSL_SETUP;
					step_d = 3'd0;
					is_read_d = ctrl_q[fpsl_pkg::CTRL_RD];
					case (ctrl_q[10:8])
						fpsl_pkg::CMD_ENTER_SEC: nsteps_d = 3'd3;
						fpsl_pkg::CMD_EXIT_SEC: nsteps_d = 3'd4;
						fpsl_pkg::CMD_ID_READ: nsteps_d = 3'd4;
						default: nsteps_d = 3'd1;
					endcase
				end
			end
			fpsl_pkg::FPSL_SETUP: begin
				// address stable before strobes fall
				st_d = fpsl_pkg::FPSL_LOW;
				cnt_d = fpsl_pkg::STROBE_CYC;
			end
			fpsl_pkg::FPSL_LOW: begin
				// strobe held well beyond the glitch window
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					st_d = fpsl_pkg::FPSL_HOLD;
					if (seq_read) begin
						rdata_d = fl_dq_in;
						if (step_q == 3'd3) begin
							sec_locked_d = fl_dq_in[fpsl_pkg::SEC_IND_BIT];
						end
					end
				end
			end
			fpsl_pkg::FPSL_HOLD: begin
				st_d = fpsl_pkg::FPSL_NEXT;
			end
			fpsl_pkg::FPSL_NEXT: begin
				if (step_q + 3'd1 >= nsteps_q) begin
					st_d = fpsl_pkg::FPSL_IDLE;
					if (ctrl_q[10:8] == fpsl_pkg::CMD_ENTER_SEC) begin
						in_sec_d = 1'b1;
					end
					if (ctrl_q[10:8] == fpsl_pkg::CMD_EXIT_SEC ||
						ctrl_q[10:8] == fpsl_pkg::CMD_RESET) begin
						in_sec_d = 1'b0;
					end
				end else begin
					st_d = fpsl_pkg::FPSL_SETUP;
					step_d = step_q + 3'd1;
				end
			end
			default: st_d = fpsl_pkg::FPSL_IDLE;
		endcase
		// hardware reset pin low drops the device out of security mode
		if (ctrl_q[fpsl_pkg::CTRL_RST_ID] == 1'b0 && !fl_reset_n) begin
			in_sec_d = 1'b0;
		end
	end

	// read port: data one cycle after the strobe
	always_comb begin
		rd_d = 32'h00000000;
		if (sw_rd) begin
			case (sw_addr)
				fpsl_pkg::REG_CTRL: rd_d = {21'h000000, ctrl_q};
				fpsl_pkg::REG_ADDR: rd_d = {10'h000, addr_q};
				fpsl_pkg::REG_WDATA: rd_d = {16'h0000, wdata_q};
				fpsl_pkg::REG_STATUS:
					rd_d = {29'h00000000, sec_locked_q, in_sec_q, busy};
				fpsl_pkg::REG_RDATA: rd_d = {16'h0000, rdata_q};
				default: rd_d = 32'h00000000;
			endcase
		end
	end

	// all state registers except the pin outputs, which have their own block below
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_q <= 11'h000;
			addr_q <= 22'h000000;
			wdata_q <= 16'h0000;
			rdata_q <= 16'h0000;
			rd_q <= 32'h00000000;
			in_sec_q <= 1'b0;
			sec_locked_q <= 1'b0;
			st_q <= fpsl_pkg::FPSL_IDLE;
			cnt_q <= 4'h0;
			step_q <= 3'd0;
			nsteps_q <= 3'd1;
			is_read_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			rd_q <= rd_d;
			in_sec_q <= in_sec_d;
			sec_locked_q <= sec_locked_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			step_q <= step_d;
			nsteps_q <= nsteps_d;
			is_read_q <= is_read_d;
		end
	end

	// pin outputs: strobes low only one cycle behind the low phase, oe held high on
	// writes so ce and we low never collide with an output drive
	logic low_ph;
	assign low_ph = (st_q == fpsl_pkg::FPSL_LOW);
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			fl_ce_n <= 1'b1;
			fl_oe_n <= 1'b1;
			fl_we_n <= 1'b1;
			fl_addr <= 22'h000000;
			fl_dq_out <= 16'h0000;
			fl_dq_oe_n <= 1'b1;
		end else begin
			// strobes trail the low phase by one cycle so the address,
			// set up in the setup phase, settles before they fall
			fl_ce_n <= !low_ph;
			fl_we_n <= !(low_ph && !seq_read);
			fl_oe_n <= !(low_ph && seq_read);
			fl_addr <= seq_addr;
			fl_dq_out <= seq_data;
			fl_dq_oe_n <= !(st_d != fpsl_pkg::FPSL_IDLE && !seq_read);
		end
	end
	// level pins straight from the control register; reset pin tied high
	assign fl_reset_n = 1'b1;
	assign fl_reset_id = ctrl_q[fpsl_pkg::CTRL_RST_ID];
	assign fl_a9_id = ctrl_q[fpsl_pkg::CTRL_A9_ID];
	assign write_protect_accel_pin = !ctrl_q[fpsl_pkg::CTRL_WP_LOW];
	assign sw_rdata = rd_q;

	// checks
	strobe_excl_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!(!fl_we_n && !fl_oe_n)) else $error("we and oe low together");
	write_ce_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!fl_we_n |-> !fl_ce_n && fl_oe_n) else $error("bad write");
	pulse_len_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$fell(fl_ce_n) |-> !fl_ce_n [*2]) else $error("short pulse");
	addr_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!fl_ce_n |-> $stable(fl_addr)) else $error("addr moved");
	data_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(fl_we_n) |-> $past(fl_dq_oe_n) == 1'b0)
		else $error("data not driven at rise");
	rd_delay_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		sw_rd && sw_addr == fpsl_pkg::REG_CTRL |=>
		sw_rdata[10:0] == $past(ctrl_q)) else $error("read late");
	enter_sec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_q == fpsl_pkg::FPSL_NEXT && step_q == 3'd2 &&
		ctrl_q[10:8] == fpsl_pkg::CMD_ENTER_SEC |=> in_sec_q)
		else $error("security mode not set");
	wp_pin_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		ctrl_q[fpsl_pkg::CTRL_WP_LOW] |-> !write_protect_accel_pin)
		else $error("wp not low");
	cov_write_c: cover property (@(posedge sys_clk) $rose(fl_we_n));
	cov_read_c: cover property (@(posedge sys_clk) $rose(fl_oe_n));
	cov_sec_c: cover property (@(posedge sys_clk) $rose(in_sec_q));
endmodule

// ### tb/fpsl_flash_model.sv
// behavioural flash part facing the host controller
`timescale 1ns/10ps
module fpsl_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h5E, // arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h3C1D, // arbitrary value
	parameter logic IND = 1'b1 // factory-locked part
) (
	input wire logic [21:0] fl_addr,
	input wire logic [15:0] fl_dq_out,
	input wire logic fl_dq_oe_n,
	output logic [15:0] fl_dq_in,
	input wire logic fl_ce_n,
	input wire logic fl_oe_n,
	input wire logic fl_we_n,
	input wire logic fl_reset_n,
	input wire logic fl_reset_id,
	input wire logic fl_a9_id,
	input wire logic write_protect_accel_pin,
	output logic sec_mode
);
	logic [21:0] al; // address taken on the later falling strobe
	logic armed; // a write cycle is open
	logic [1:0] st; // unlock progress
	logic idm; // id readout mode
	logic tog; // keeps a released bus wandering
	logic prot; // outer boot sector blocked now
	logic [15:0] rv; // value the part presents
	// power-up lands in read array
	initial begin
		{al, armed, st, idm, sec_mode, tog} = '0;
	end
	always #25 tog = ~tog;
	// open a write only on a legal strobe mix
	always @(negedge fl_we_n or negedge fl_ce_n) begin
		if (!fl_we_n && !fl_ce_n && fl_oe_n) begin
			al = fl_addr;
			armed = 1'b1;
		end
	end
	// data taken on the earlier rising strobe, then decoded
	always @(posedge fl_we_n or posedge fl_ce_n or negedge fl_reset_n) begin
		if (!fl_reset_n) begin
			{st, idm, sec_mode} = '0;
		end else if (armed) begin
			armed = 1'b0;
			if (fl_dq_out == 16'h00F0) {st, idm} = '0;
			else if (st == 0 && al[10:0] == 11'h555 && fl_dq_out == 16'h00AA)
				st = 2'd1;
			else if (st == 1 && al[10:0] == 11'h2AA && fl_dq_out == 16'h0055)
				st = 2'd2;
			else if (st == 2 && fl_dq_out == 16'h0088) {st, sec_mode} = 3'h1;
			else if (st == 2 && fl_dq_out == 16'h0090) {st, idm} = 3'h7;
			else if (st == 3 && fl_dq_out == 16'h0000) {st, idm, sec_mode} = '0;
			else st = 2'd0;
		end
	end
	// read mux; protection ignores stored state as none is stored
	always_comb begin
		prot = !fl_reset_id && !write_protect_accel_pin;
		prot = prot && fl_addr[20:13] == 8'h00;
		if (fl_a9_id && fl_addr[1]) rv = {15'h0, prot};
		else if (fl_a9_id) rv = fl_addr[0] ? DEV_CODE : {8'h00, MAKER_CODE};
		else if (idm) rv = {8'h00, IND, 7'h19};
		else rv = sec_mode ? fl_addr[15:0] ^ 16'h5A5A : fl_addr[15:0];
	end
	assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rv : {16{tog}} ^ 16'h3C3C;
endmodule

// ### tb/test_flash_protection_security_logic.sv
// self-checking bench for the flash protection host controller
`timescale 1ns/10ps
module test_flash_protection_security_logic;
	localparam logic [7:0] MAKER = 8'h5E; // arbitrary value
	localparam logic [15:0] DEVC = 16'h3C1D; // arbitrary value
	localparam logic IND = 1'b1; // factory-locked part
	localparam logic [21:0] TA [7] = '{0, 1, 2, 22'h1002, 22'h2002, 2, 2};
	localparam logic [4:0] TB [7] = '{5'h10, 5'h10, 5'h14, 5'h14, 5'h14,
		5'h1C, 5'h10};
	localparam logic [15:0] TX [7] = '{{8'h00, MAKER}, DEVC, 1, 1, 0, 0, 0};
	logic sys_clk, nrst, sw_wr, sw_rd, pend, sec_mode, fl_dq_oe_n;
	logic fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_reset_id, fl_a9_id;
	logic write_protect_accel_pin;
	logic [3:0] sw_addr;
	logic [31:0] sw_wdata, sw_rdata, st, a;
	logic [21:0] fl_addr;
	logic [15:0] fl_dq_out, fl_dq_in;
	logic [63:0] q[$]; // mask and value of each expected read
	logic [63:0] e;
	int fails, num_checks;
	fpsl_host fpsl_host_inst (.sys_clk(sys_clk), .nrst(nrst),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
		.fl_dq_oe_n(fl_dq_oe_n), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n),
		.fl_reset_id(fl_reset_id), .fl_a9_id(fl_a9_id),
		.write_protect_accel_pin(write_protect_accel_pin));
	fpsl_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVC), .IND(IND))
		fpsl_flash_model_inst (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
		.fl_dq_oe_n(fl_dq_oe_n), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n),
		.fl_reset_id(fl_reset_id), .fl_a9_id(fl_a9_id),
		.write_protect_accel_pin(write_protect_accel_pin),
		.sec_mode(sec_mode));
	// 50 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic summarize;
		if (fails == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(logic [31:0] g, logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// read data stand only in the cycle after the strobe
	always @(negedge sys_clk) begin
		if (pend) begin
			e = q.pop_front();
			if (e[63:32] != 0) chk(sw_rdata & e[63:32], e[31:0]);
		end
		pend = sw_rd;
	end
	task automatic rd(logic [3:0] ad, logic [31:0] x, logic [31:0] m);
		q.push_back({m, x});
		@(posedge sys_clk);
		sw_addr <= ad;
		sw_rd <= 1'b1;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
	endtask
	task automatic wr(logic [3:0] ad, logic [31:0] d);
		@(posedge sys_clk);
		sw_addr <= ad;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask
	// start a command, then poll busy under a bound
	task automatic cmd(logic [2:0] c, logic [4:0] bits);
		wr(fpsl_pkg::REG_CTRL, {21'h0, c, 3'h0, bits | 5'h01});
		for (int i = 0; i < 100; i++) begin
			rd(fpsl_pkg::REG_STATUS, 0, 0);
			@(negedge sys_clk);
			st = sw_rdata;
			if (st[0] === 1'b0) break;
		end
		if (st[0] !== 1'b0) chk(st, 0);
	endtask
	task automatic raw(logic [21:0] ad, logic [4:0] b, logic [31:0] x);
		wr(fpsl_pkg::REG_ADDR, {10'h0, ad});
		cmd(fpsl_pkg::CMD_RAW, b | 5'h02);
		rd(fpsl_pkg::REG_RDATA, x, 32'hFFFF);
	endtask
	// watchdog, far beyond the expected run
	initial begin
		#1000000;
		fails++;
		summarize();
	end
	initial begin
		nrst = 1'b0;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		sw_addr = 4'h0;
		sw_wdata = 32'h0;
		pend = 1'b0;
		void'($urandom(32'hDBA8));
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(fpsl_pkg::REG_STATUS, 0, 32'hFFFFFFFF);
		rd(4'hF, 0, 32'hFFFFFFFF);
		// random plain writes and reads
		for (int i = 0; i < 4; i++) begin
			a = $urandom;
			wr(fpsl_pkg::REG_WDATA, a);
			wr(fpsl_pkg::REG_ADDR, {10'h0, a[21:0]});
			cmd(fpsl_pkg::CMD_RAW, 5'h0);
			raw(a[31:10], 5'h0, {16'h0, a[25:10]});
		end
		cmd(fpsl_pkg::CMD_ENTER_SEC, 5'h0);
		chk(sec_mode, 1);
		rd(fpsl_pkg::REG_STATUS, 2, 2);
		raw(22'h10, 5'h0, 32'h5A4A);
		cmd(fpsl_pkg::CMD_EXIT_SEC, 5'h0);
		chk(sec_mode, 0);
		rd(fpsl_pkg::REG_STATUS, 0, 2);
		raw(22'h10, 5'h0, 32'h10);
		wr(fpsl_pkg::REG_ADDR, 32'h3);
		cmd(fpsl_pkg::CMD_ID_READ, 5'h0);
		rd(fpsl_pkg::REG_STATUS, {29'h0, IND, 2'h0}, 4);
		rd(fpsl_pkg::REG_RDATA, {24'h0, IND, 7'h19}, 32'hFF);
		cmd(fpsl_pkg::CMD_RESET, 5'h0);
		// id pin readouts across protect pin settings
		for (int i = 0; i < 7; i++) begin
			raw(TA[i], TB[i], {16'h0, TX[i]});
			chk(write_protect_accel_pin, !TB[i][2]);
			chk(fl_reset_id, TB[i][3]);
			chk(fl_a9_id, 1);
		end
		summarize();
	end
endmodule
